// ===== src/twic_params.svh
/*
  timer, watchdog and interrupt controller: offsets, field positions, reset values and counts.
  assumes it is included by bare name from the package and bench files.
*/
`ifndef TWIC_PARAMS_SVH
`define TWIC_PARAMS_SVH

// ----------------------------------------------------------------------------
// sources and vectors
// ----------------------------------------------------------------------------
`define TWIC_NSRC          13
`define TWIC_VEC_BASE      16'h3FF0

// ----------------------------------------------------------------------------
// register offsets (word addresses on the plain port)
// ----------------------------------------------------------------------------
`define TWIC_OFS_STATUS    4'h0
`define TWIC_OFS_MASK      4'h1
`define TWIC_OFS_ACK       4'h2
`define TWIC_OFS_VECTOR    4'h3
`define TWIC_OFS_TMR_CTRL  4'h4
`define TWIC_OFS_TMR_LOAD  4'h5
`define TWIC_OFS_TMR_COUNT 4'h6
`define TWIC_OFS_WDG_LOAD  4'h7
`define TWIC_OFS_WDG_KICK  4'h8
`define TWIC_OFS_PRIO_LO   4'h9
`define TWIC_OFS_PRIO_HI   4'hA
`define TWIC_OFS_PRIO_TOP  4'hB
`define TWIC_OFS_PRIO_END  4'hC

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define TWIC_TMR_RUN_BIT   0
`define TWIC_TMR_CONT_BIT  1
`define TWIC_TMR_PRE_LSB   4
`define TWIC_TMR_LOAD_RST  12'hFFF
`define TWIC_WDG_LOAD_RST  16'hFFFF
`define TWIC_WDG_KEY       16'hA5C3
`define TWIC_MASK_RST      13'h0000
// source i starts at level i, so the order is fixed until software moves it
`define TWIC_PRIO_RST      52'hCBA9876543210

`endif

// ===== src/twic_pkg.sv
/*
  types shared by the timer, watchdog and interrupt controller files.
  assumes twic_params.svh is on the include path.
*/
`include "twic_params.svh"

package twic_pkg;
  typedef logic [`TWIC_NSRC-1:0] twic_src_t;
  typedef logic [3:0]            twic_prio_t;

  // plain register port from the dsp core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } twic_bus_s;

  typedef enum logic [1:0] {
    TWIC_WDG_ARMED,
    TWIC_WDG_WARNED,
    TWIC_WDG_RESET
  } twic_wdg_e;
endpackage : twic_pkg

// ===== src/twic_general_timer_irq.sv
/*
  general-purpose timer: 12-bit down-counter behind an 8-bit prescaler set by a 3-bit divide select.
  assumes clk_i domain control from the register block.
*/
`timescale 1ns/10ps
`default_nettype none

module twic_general_timer_irq
  import twic_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // control
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        cont_i,
  input  wire logic [2:0]  pre_i,
  input  wire logic [11:0] load_i,
  // status
  output logic             running_o,
  output logic [11:0]      count_o,
  output logic             expire_o
);
  logic        run_reg,   run_next;
  logic [11:0] cnt_reg,   cnt_next;
  logic [7:0]  pre_reg,   pre_next;
  logic        exp_reg,   exp_next;
  logic        tick;

  // prescale divides by 2^pre
  assign tick = (pre_reg == ((8'h01 << pre_i) - 8'h01));

  always_comb
  begin
    run_next = run_reg;
    cnt_next = cnt_reg;
    pre_next = pre_reg;
    exp_next = 1'b0;
    if (start_i)
    begin
      run_next = 1'b1;
      cnt_next = load_i;
      pre_next = 8'h00;
    end
    else if (stop_i)
      run_next = 1'b0;
    else if (run_reg)
    begin
      pre_next = tick ? 8'h00 : pre_reg + 8'h01;
      if (tick)
      begin
        if (cnt_reg == 12'h000)
        begin
          exp_next = 1'b1;
          if (cont_i)
            cnt_next = load_i;
          else
            run_next = 1'b0;
        end
        else
          cnt_next = cnt_reg - 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      run_reg <= 1'b0;
      cnt_reg <= 12'h000;
      pre_reg <= 8'h00;
      exp_reg <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      cnt_reg <= cnt_next;
      pre_reg <= pre_next;
      exp_reg <= exp_next;
    end
  end

  assign running_o = run_reg;
  assign count_o   = cnt_reg;
  assign expire_o  = exp_reg;

  a_oneshot_stops: assert property (@(posedge clk_i) disable iff (reset_i)
    exp_reg && !cont_i && !start_i && !$past(start_i) |-> !run_reg)
    else $error("single-shot timer kept running after expiry");
  a_expiry_at_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    exp_reg |-> $past(cnt_reg) == 12'h000)
    else $error("timer expiry without zero count");
endmodule : twic_general_timer_irq

`default_nettype wire

// ===== src/twic_watchdog.sv
/*
  watchdog: counts system clocks, warns on the first timeout, resets on the second.
  assumes the kick pulse comes from a keyed register write.
*/
`timescale 1ns/10ps
`default_nettype none

module twic_watchdog
  import twic_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // control
  input  wire logic [15:0] load_i,
  input  wire logic        kick_i,
  // events
  output logic             timeout_o,
  output logic             chip_reset_o
);
  twic_wdg_e   st_reg,  st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        to_reg,  to_next;

  // no enable input exists: the watchdog cannot be switched off
  always_comb
  begin
    st_next  = st_reg;
    cnt_next = cnt_reg - 16'h0001;
    to_next  = 1'b0;
    case (st_reg)
      TWIC_WDG_ARMED, TWIC_WDG_WARNED:
      begin
        if (kick_i)
        begin
          cnt_next = load_i;
          st_next  = TWIC_WDG_ARMED;
        end
        else if (cnt_reg == 16'h0000)
        begin
          cnt_next = load_i;
          if (st_reg == TWIC_WDG_ARMED)
          begin
            to_next = 1'b1;
            st_next = TWIC_WDG_WARNED;
          end
          else
            st_next = TWIC_WDG_RESET;
        end
      end
      TWIC_WDG_RESET:
        cnt_next = cnt_reg;
      default:
        st_next = TWIC_WDG_ARMED;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_reg  <= TWIC_WDG_ARMED;
      cnt_reg <= `TWIC_WDG_LOAD_RST;
      to_reg  <= 1'b0;
    end
    else
    begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      to_reg  <= to_next;
    end
  end

  assign timeout_o    = to_reg;
  assign chip_reset_o = (st_reg == TWIC_WDG_RESET);

  a_second_resets: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg == TWIC_WDG_WARNED && cnt_reg == 16'h0000 && !kick_i |=> chip_reset_o)
    else $error("second timeout did not reset");
  a_first_warns: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg == TWIC_WDG_ARMED && cnt_reg == 16'h0000 && !kick_i |=> timeout_o && !chip_reset_o)
    else $error("first timeout did not warn");
  a_always_counts: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg != TWIC_WDG_RESET && !kick_i && cnt_reg != 16'h0000 |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("watchdog stopped counting");
endmodule : twic_watchdog

`default_nettype wire

// ===== src/twic_irq_ctrl.sv
/*
  interrupt controller with general timer and watchdog for the dsp core.
  assumes a plain register port driven on clk_i; sources are same-clock pulses.
*/
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module twic_irq_ctrl
  import twic_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // interrupt sources, same-clock pulses
  input  wire logic        filterbank_done_irq_i,
  input  wire logic        audio_block_full_irq_i,
  input  wire logic        spi_irq_i,
  input  wire logic        remote_control_irq_i,
  input  wire logic        extension_receive_irq_i,
  input  wire logic        extension_transmit_irq_i,
  input  wire logic        pin_port_irq_i,
  input  wire logic        two_wire_irq_i,
  input  wire logic        serial_receive_irq_i,
  input  wire logic        serial_transmit_irq_i,
  input  wire logic        sample_link_irq_i,
  // core side
  input  wire logic        set_irq_enable_instr_i,
  input  wire logic        clr_irq_enable_i,
  output logic             irq_o,
  output logic [15:0]      irq_vector_o,
  output logic             device_reset_o
);
  import twic_pkg::*;

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  twic_bus_s   bus;
  twic_src_t   pend_reg, pend_next;
  twic_src_t   mask_reg, mask_next;
  twic_src_t   ackf_reg, ackf_next;
  twic_src_t   src;
  logic        gie_reg,  gie_next;
  logic [1:0]  tctl_reg, tctl_next;
  logic [2:0]  tpre_reg, tpre_next;
  logic [11:0] tload_reg, tload_next;
  logic [15:0] wload_reg, wload_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [51:0] prio_reg, prio_next;
  logic        tmr_start, tmr_stop, wdg_kick;
  logic        tmr_run, tmr_exp, wdg_to, wdg_rst;
  logic [11:0] tmr_cnt;

  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  // source order fixed: bit index is the source number
  assign src = {sample_link_irq_i, serial_transmit_irq_i, serial_receive_irq_i,
                two_wire_irq_i, pin_port_irq_i, extension_transmit_irq_i,
                extension_receive_irq_i, remote_control_irq_i, spi_irq_i,
                wdg_to, tmr_exp, audio_block_full_irq_i, filterbank_done_irq_i};

  // --------------------------------------------------------------------------
  // timers
  // --------------------------------------------------------------------------
  assign tmr_start = bus.wr && bus.addr == `TWIC_OFS_TMR_CTRL && bus.wdata[`TWIC_TMR_RUN_BIT];
  assign tmr_stop  = bus.wr && bus.addr == `TWIC_OFS_TMR_CTRL && !bus.wdata[`TWIC_TMR_RUN_BIT];
  // keyed write so a runaway store cannot feed the dog
  assign wdg_kick  = bus.wr && bus.addr == `TWIC_OFS_WDG_KICK && bus.wdata == `TWIC_WDG_KEY;

  twic_general_timer_irq u_general_timer_irq (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .start_i   (tmr_start),
    .stop_i    (tmr_stop),
    .cont_i    (tctl_reg[`TWIC_TMR_CONT_BIT]),
    .pre_i     (tpre_reg),
    .load_i    (tload_reg),
    .running_o (tmr_run),
    .count_o   (tmr_cnt),
    .expire_o  (tmr_exp)
  );

  twic_watchdog u_watchdog (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .load_i       (wload_reg),
    .kick_i       (wdg_kick),
    .timeout_o    (wdg_to),
    .chip_reset_o (wdg_rst)
  );

  // --------------------------------------------------------------------------
  // priority select: lowest level wins, ties to lower source index
  // --------------------------------------------------------------------------
  twic_src_t  live;
  logic       win_valid;
  logic [3:0] win_idx;
  twic_prio_t win_lvl;

  assign live = pend_reg & mask_reg;

  always_comb
  begin
    win_valid = 1'b0;
    win_idx   = 4'h0;
    win_lvl   = 4'hF;
    for (int i = 0; i < `TWIC_NSRC; i++)
    begin
      if (live[i] && (!win_valid || prio_reg[i*4 +: 4] < win_lvl))
      begin
        win_valid = 1'b1;
        win_idx   = 4'(i);
        win_lvl   = prio_reg[i*4 +: 4];
      end
    end
  end

  // --------------------------------------------------------------------------
  // register next-state
  // --------------------------------------------------------------------------
  always_comb
  begin
    pend_next  = pend_reg | src;
    ackf_next  = ackf_reg;
    mask_next  = mask_reg;
    gie_next   = gie_reg;
    tctl_next  = tctl_reg;
    tpre_next  = tpre_reg;
    tload_next = tload_reg;
    wload_next = wload_reg;
    prio_next  = prio_reg;
    rdata_next = 16'h0000;
    if (set_irq_enable_instr_i)
      gie_next = 1'b1;
    else if (clr_irq_enable_i)
      gie_next = 1'b0;
    if (bus.wr)
    begin
      case (bus.addr)
        `TWIC_OFS_STATUS,
        `TWIC_OFS_ACK:
        begin
          // write one clears, but a same-cycle event wins
          pend_next = (pend_reg & ~bus.wdata[`TWIC_NSRC-1:0]) | src;
          ackf_next = ackf_reg | (pend_reg & bus.wdata[`TWIC_NSRC-1:0]);
        end
        `TWIC_OFS_MASK:     mask_next  = bus.wdata[`TWIC_NSRC-1:0];
        `TWIC_OFS_TMR_CTRL:
        begin
          tctl_next = bus.wdata[1:0];
          tpre_next = bus.wdata[`TWIC_TMR_PRE_LSB +: 3];
        end
        `TWIC_OFS_TMR_LOAD: tload_next = bus.wdata[11:0];
        `TWIC_OFS_WDG_LOAD: wload_next = bus.wdata;
        `TWIC_OFS_PRIO_LO:  prio_next[15:0]  = bus.wdata;
        `TWIC_OFS_PRIO_HI:  prio_next[31:16] = bus.wdata;
        `TWIC_OFS_PRIO_TOP: prio_next[47:32] = bus.wdata;
        `TWIC_OFS_PRIO_END: prio_next[51:48] = bus.wdata[3:0];
        default: ;
      endcase
    end
    // fresh event on a source clears its old acknowledge flag
    ackf_next = ackf_next & ~src;
    if (bus.rd)
    begin
      case (bus.addr)
        `TWIC_OFS_STATUS:    rdata_next = {3'h0, pend_reg};
        `TWIC_OFS_MASK:      rdata_next = {3'h0, mask_reg};
        `TWIC_OFS_ACK:       rdata_next = {3'h0, ackf_reg};
        `TWIC_OFS_VECTOR:    rdata_next = {11'h000, win_valid, win_idx};
        `TWIC_OFS_TMR_CTRL:  rdata_next = {9'h000, tpre_reg, 2'h0, tctl_reg[1], tmr_run};
        `TWIC_OFS_TMR_LOAD:  rdata_next = {4'h0, tload_reg};
        `TWIC_OFS_TMR_COUNT: rdata_next = {4'h0, tmr_cnt};
        `TWIC_OFS_WDG_LOAD:  rdata_next = wload_reg;
        `TWIC_OFS_PRIO_LO:   rdata_next = prio_reg[15:0];
        `TWIC_OFS_PRIO_HI:   rdata_next = prio_reg[31:16];
        `TWIC_OFS_PRIO_TOP:  rdata_next = prio_reg[47:32];
        `TWIC_OFS_PRIO_END:  rdata_next = {12'h000, prio_reg[51:48]};
        default:             rdata_next = 16'h0000;
      endcase
    end
  end

  // reset branch loads constants only; the level table comes from the header
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pend_reg  <= '0;
      ackf_reg  <= '0;
      mask_reg  <= `TWIC_MASK_RST;
      gie_reg   <= 1'b0;
      tctl_reg  <= 2'h0;
      tpre_reg  <= 3'h0;
      tload_reg <= `TWIC_TMR_LOAD_RST;
      wload_reg <= `TWIC_WDG_LOAD_RST;
      prio_reg  <= `TWIC_PRIO_RST;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      pend_reg  <= pend_next;
      ackf_reg  <= ackf_next;
      mask_reg  <= mask_next;
      gie_reg   <= gie_next;
      tctl_reg  <= tctl_next;
      tpre_reg  <= tpre_next;
      tload_reg <= tload_next;
      wload_reg <= wload_next;
      prio_reg  <= prio_next;
      rdata_reg <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign irq_o          = gie_reg && win_valid;
  assign irq_vector_o   = `TWIC_VEC_BASE + {12'h000, win_idx};
  assign rdata_o        = rdata_reg;
  // the system reset tree must feed this back into reset_i
  assign device_reset_o = wdg_rst;

  a_gie_gates: assert property (@(posedge clk_i) disable iff (reset_i)
    irq_o |-> gie_reg && (live != '0))
    else $error("interrupt delivered while disabled or idle");
  a_pend_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    pend_reg[0] && !(bus.wr && (bus.addr == `TWIC_OFS_STATUS || bus.addr == `TWIC_OFS_ACK)) |=> pend_reg[0])
    else $error("pending request lost without acknowledge");
  a_timer_source: assert property (@(posedge clk_i) disable iff (reset_i)
    tmr_exp |=> pend_reg[2])
    else $error("timer expiry not pending");
  a_vector_unique: assert property (@(posedge clk_i) disable iff (reset_i)
    win_valid |-> irq_vector_o == `TWIC_VEC_BASE + {12'h000, win_idx} && live[win_idx])
    else $error("vector does not name a live source");
  a_ack_on_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    bus.wr && bus.addr == `TWIC_OFS_STATUS && bus.wdata[0] && pend_reg[0] && !src[0] |=> ackf_reg[0] && !pend_reg[0])
    else $error("cleared request left no acknowledge flag");
endmodule : twic_irq_ctrl

`default_nettype wire

// ===== test/twic_core_model.sv
/*
  dsp core stand-in: issues the enable and disable instructions, latches the vector it would branch to.
  assumes the core sees the interrupt channel on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module twic_core_model
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // interrupt channel
  input  wire logic        irq_i,
  input  wire logic [15:0] vector_i,
  output logic             set_irq_enable_instr_o,
  output logic             clr_ie_o
);
  logic [15:0] taken_vec;

  initial
  begin
    set_irq_enable_instr_o = 1'b0;
    clr_ie_o = 1'b0;
  end

  // ----------------------------------------------------------------------------
  // instructions
  // ----------------------------------------------------------------------------
  task enable_irq();
    @(posedge clk_i);
    set_irq_enable_instr_o <= 1'b1;
    @(posedge clk_i);
    set_irq_enable_instr_o <= 1'b0;
  endtask : enable_irq

  task disable_irq();
    @(posedge clk_i);
    clr_ie_o <= 1'b1;
    @(posedge clk_i);
    clr_ie_o <= 1'b0;
  endtask : disable_irq

  // branch target follows the winning source
  always @(posedge clk_i or posedge reset_i)
    if (reset_i)
      taken_vec <= 16'h0000;
    else if (irq_i)
      taken_vec <= vector_i;
endmodule : twic_core_model
`default_nettype wire

// ===== test/timer_watchdog_irq_ctrl_bench.sv
/*
  self-checking bench for the timer, watchdog and interrupt controller.
  assumes the design files and twic_core_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "twic_params.svh"

module timer_watchdog_irq_ctrl_bench;
  import twic_pkg::*;
  logic        clk_i;
  logic        reset_i;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [15:0] vec;
  logic [10:0] src;
  logic        set_irq_enable_instr;
  logic        clr_ie;
  logic        irq;
  logic        dev_rst;
  logic [15:0] d;
  int          errors;
  int          compares;
  int          cyc;
  int          n;
  int          t0;

  initial
  begin
    clk_i = 1'b0; reset_i = 1'b1; addr = 4'h0; wdata = 16'h0000;
    wr = 1'b0; rd = 1'b0; src = 11'h000;
    errors = 0; compares = 0; cyc = 0;
  end
  always #50 clk_i = ~clk_i;

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      test_done();
    end
  end

  twic_irq_ctrl dut (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .filterbank_done_irq_i(src[0]), .audio_block_full_irq_i(src[1]),
    .spi_irq_i(src[2]), .remote_control_irq_i(src[3]), .extension_receive_irq_i(src[4]),
    .extension_transmit_irq_i(src[5]), .pin_port_irq_i(src[6]), .two_wire_irq_i(src[7]),
    .serial_receive_irq_i(src[8]), .serial_transmit_irq_i(src[9]), .sample_link_irq_i(src[10]),
    .set_irq_enable_instr_i(set_irq_enable_instr), .clr_irq_enable_i(clr_ie), .irq_o(irq),
    .irq_vector_o(vec), .device_reset_o(dev_rst));

  twic_core_model core (
    .clk_i(clk_i), .reset_i(reset_i), .irq_i(irq), .vector_i(vec), .set_irq_enable_instr_o(set_irq_enable_instr), .clr_ie_o(clr_ie));

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr <= a; rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    v = rdata;
  endtask : rd_reg

  task pulse(input logic [10:0] m);
    @(posedge clk_i);
    src <= m;
    @(posedge clk_i);
    src <= 11'h000;
    @(negedge clk_i);
  endtask : pulse

  task wait_irq(input int lim, output int k);
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(negedge clk_i);
      k++;
    end
  endtask : wait_irq

  task apply_reset();
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
  endtask : apply_reset

  // external sources skip the two timer indices
  function automatic int idx(input int j);
    return (j < 2) ? j : j + 2;
  endfunction : idx

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task t_reset();
    rd_reg(`TWIC_OFS_MASK, d); chk(d, 16'(`TWIC_MASK_RST));
    rd_reg(`TWIC_OFS_TMR_LOAD, d); chk(d, 16'(`TWIC_TMR_LOAD_RST));
    rd_reg(4'hD, d); chk(d, 16'h0000);
    chk(vec, `TWIC_VEC_BASE);
    chk(16'(irq), 16'h0000);
  endtask : t_reset

  task t_watchdog();
    wr_reg(`TWIC_OFS_MASK, 16'h0008);
    core.enable_irq();
    wr_reg(`TWIC_OFS_WDG_LOAD, 16'h0020);
    wr_reg(`TWIC_OFS_WDG_KICK, `TWIC_WDG_KEY);
    wait_irq(45, n);
    chk(16'(irq), 16'h0001);
    chk(16'(dev_rst), 16'h0000);
    wr_reg(`TWIC_OFS_WDG_KICK, `TWIC_WDG_KEY);
    wr_reg(`TWIC_OFS_STATUS, 16'h0008);
    repeat (25) @(negedge clk_i);
    chk(16'(irq | dev_rst), 16'h0000);
    repeat (20) @(negedge clk_i);
    chk(16'(irq), 16'h0001);
    chk(16'(dev_rst), 16'h0000);
    repeat (40) @(negedge clk_i);
    chk(16'(dev_rst), 16'h0001);
    apply_reset();
    chk(16'(dev_rst), 16'h0000);
  endtask : t_watchdog

  task t_sources();
    wr_reg(`TWIC_OFS_MASK, 16'h1FFF);
    core.enable_irq();
    for (int j = 0; j < 11; j++)
    begin
      pulse(11'(1 << j));
      chk(16'(irq), 16'h0001);
      chk(vec, `TWIC_VEC_BASE + 16'(idx(j)));
      rd_reg(`TWIC_OFS_STATUS, d); chk(d, 16'(1 << idx(j)));
      chk(core.taken_vec, `TWIC_VEC_BASE + 16'(idx(j)));
      wr_reg(`TWIC_OFS_STATUS, 16'(1 << idx(j)));
      rd_reg(`TWIC_OFS_ACK, d); chk(d & 16'(1 << idx(j)), 16'(1 << idx(j)));
      chk(16'(irq), 16'h0000);
    end
    core.disable_irq();
    pulse(11'h001);
    chk(16'(irq), 16'h0000);
    core.enable_irq();
    @(negedge clk_i);
    chk(16'(irq), 16'h0001);
    wr_reg(`TWIC_OFS_STATUS, 16'h0001);
  endtask : t_sources

  task t_priority();
    pulse(11'h401);
    chk(vec, `TWIC_VEC_BASE);
    // demote filterbank below sample link
    wr_reg(`TWIC_OFS_PRIO_LO, 16'h321F);
    wr_reg(`TWIC_OFS_PRIO_END, 16'h0000);
    @(negedge clk_i);
    chk(vec, `TWIC_VEC_BASE + 16'h000C);
    wr_reg(`TWIC_OFS_STATUS, 16'h1000);
    @(negedge clk_i);
    chk(vec, `TWIC_VEC_BASE);
    chk(16'(irq), 16'h0001);
    wr_reg(`TWIC_OFS_STATUS, 16'h0001);
  endtask : t_priority

  task t_timer();
    wr_reg(`TWIC_OFS_MASK, 16'h0004);
    wr_reg(`TWIC_OFS_TMR_LOAD, 16'h0003);
    wr_reg(`TWIC_OFS_TMR_CTRL, 16'h0011);
    wait_irq(20, n);
    chk(16'(n >= 6 && n <= 17), 16'h0001);
    wr_reg(`TWIC_OFS_STATUS, 16'h0004);
    repeat (40) @(negedge clk_i);
    chk(16'(irq), 16'h0000);
    wr_reg(`TWIC_OFS_TMR_CTRL, 16'h0011);
    wait_irq(20, n);
    chk(16'(irq), 16'h0001);
    wr_reg(`TWIC_OFS_TMR_CTRL, 16'h0000);
    wr_reg(`TWIC_OFS_STATUS, 16'h0004);
    // continuous, prescale 4: period (3+1)*4
    wr_reg(`TWIC_OFS_TMR_CTRL, 16'h0023);
    wait_irq(40, n);
    for (int k = 0; k < 2; k++)
    begin
      t0 = cyc;
      wr_reg(`TWIC_OFS_STATUS, 16'h0004);
      @(negedge clk_i);
      wait_irq(40, n);
      chk(16'(cyc - t0), 16'h0010);
    end
    wr_reg(`TWIC_OFS_TMR_CTRL, 16'h0000);
  endtask : t_timer

  initial
  begin
    apply_reset();
    t_reset();
    t_watchdog();
    t_sources();
    t_priority();
    t_timer();
    test_done();
  end
endmodule : timer_watchdog_irq_ctrl_bench
`default_nettype wire
